/* logic/e1_rx_status_pkg.sv */
// Constants, field layouts and types shared by the receive status register bank
package e1_rx_status_pkg;

  // Timing
  localparam int unsigned CLK_PERIOD_NS        = 10;
  localparam int unsigned PHASE_REFRESH_US     = 250;
  localparam int unsigned PHASE_REFRESH_CYCLES = (PHASE_REFRESH_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned LOS_MIN_MS           = 1;
  localparam int unsigned LOS_MIN_CYCLES       =
    (LOS_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W                = 17;

  // Host port
  localparam int          ADDR_W            = 8;
  localparam int          DATA_W            = 8;
  localparam logic [7:0]  ADDR_SLIP_PATTERN = 8'h13;
  localparam logic [7:0]  ADDR_BUF_PHASE    = 8'h14;
  localparam logic [7:0]  ADDR_FAS          = 8'h15;
  localparam logic [7:0]  ADDR_LINE         = 8'h16;
  localparam logic [7:0]  ADDR_DEJITTER     = 8'h17;

  // Slip and pattern word
  localparam int SLIP_TOGGLE_BIT  = 7;
  localparam int SLIP_DIR_BIT     = 6;
  localparam int OVER_FRAME_BIT   = 5;
  localparam int AUX_BIT          = 4;
  localparam int FRAME_TOGGLE_BIT = 3;
  localparam int SBD_LSB          = 0;

  // Buffer phase word
  localparam int TS_W   = 5;
  localparam int TS_MSB = TS_W - 1;
  localparam int TS_LSB = 3;
  localparam int BC_W   = 3;
  localparam int BC_LSB = 0;
  localparam int SBD_W  = 3;

  // Line and dejitter words
  localparam int LOS_BIT           = 7;
  localparam int JA_SLOW_BIT       = 7;
  localparam int JA_FAST_BIT       = 6;
  localparam int JA_EMPTY_BIT      = 5;
  localparam int JA_FOUR_USED_BIT  = 4;
  localparam int JA_HALF_BIT       = 3;
  localparam int JA_FOUR_FREE_BIT  = 2;
  localparam int JA_FULL_BIT       = 1;
  localparam int JA_FILL_W         = 6;
  localparam logic [5:0] JA_EMPTY_FILL     = 6'h00;
  localparam logic [5:0] JA_DEPTH_FILL     = 6'h20;
  localparam logic [5:0] JA_HALF_FILL      = 6'h10;
  localparam logic [5:0] JA_MARGIN         = 6'h04;
  localparam logic [5:0] JA_NEAR_FULL_FILL = JA_DEPTH_FILL - JA_MARGIN;

  // Alternating pattern detector
  localparam int         AUX_CNT_W     = 10;
  localparam logic [9:0] AUX_LAST_BIT  = 10'h1FF;
  localparam logic [9:0] AUX_ERR_LIMIT = 10'h004;

  typedef struct packed {
    logic              over;
    logic [TS_W-1:0]   ts;
    logic [BC_W-1:0]   bc;
    logic [SBD_W-1:0]  sbd;
  } phase_word_t;

  typedef enum logic [2:0] {
    LOS_CLEAR  = 3'h1,
    LOS_TIMING = 3'h2,
    LOS_LOST   = 3'h4
  } los_state_t;

endpackage

/* logic/phase_snap_if.sv */
// Carrier for the coherent buffer phase snapshot
`timescale 1ns/1ps
`default_nettype none
interface phase_snap_if;
  e1_rx_status_pkg::phase_word_t word;
  logic                          update;
  modport producer (output word, output update);
  modport consumer (input word, input update);
endinterface
`default_nettype wire

/* logic/phase_snapshot.sv */
// Periodic coherent sampler of the elastic buffer phase word
`timescale 1ns/1ps
`default_nettype none
module phase_snapshot #(
  parameter int unsigned REFRESH_CYCLES = e1_rx_status_pkg::PHASE_REFRESH_CYCLES
) (
  input  wire logic                          core_clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          ce_i,
  input  wire e1_rx_status_pkg::phase_word_t live_word_i,
  phase_snap_if.producer                     snap
);
  localparam int TW = e1_rx_status_pkg::CNT_W;

  typedef struct packed {
    logic [TW-1:0]                 timer;
    e1_rx_status_pkg::phase_word_t word;
    logic                          update;
  } snap_state_t;

  snap_state_t st_r;
  snap_state_t st_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // One capture of the whole word keeps all fields from the same instant
  always_comb begin
    st_nxt        = st_r;
    st_nxt.update = 1'b0;
    if (st_r.timer == TW'(REFRESH_CYCLES - 1)) begin // RL7
      st_nxt.timer  = '0;
      st_nxt.word   = live_word_i; // RL20
      st_nxt.update = 1'b1;
    end else begin
      st_nxt.timer = st_r.timer + TW'(1);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign snap.word   = st_r.word;
  assign snap.update = st_r.update;

  ////////////////////////////////////////////////////////////////////////////////
  coherent_word_a : assert property ( // RL20
    @(posedge core_clk_i) disable iff (rst_i)
    !$stable(st_r.word) |-> st_r.update)
    else $error("phase word changed outside a refresh");

  refresh_period_a : assert property ( // RL7
    @(posedge core_clk_i) disable iff (rst_i)
    ($past(ce_i) && st_r.update) |-> $past(st_r.timer) == TW'(REFRESH_CYCLES - 1))
    else $error("phase refresh at wrong interval");

  sub_bit_sample_a : assert property ( // RL6
    @(posedge core_clk_i) disable iff (rst_i)
    ($past(ce_i) && st_r.update) |-> st_r.word.sbd == $past(live_word_i.sbd))
    else $error("sub-bit depth not sampled");
endmodule
`default_nettype wire

/* logic/alt_pattern_detect.sv */
// Alternating one-zero pattern detector over fixed bit windows
`timescale 1ns/1ps
`default_nettype none
module alt_pattern_detect (
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic bit_i,
  input  wire logic bit_valid_i,
  output logic      seen_o
);
  localparam int CW = e1_rx_status_pkg::AUX_CNT_W;

  typedef struct packed {
    logic          prev_bit;
    logic [CW-1:0] bit_cnt;
    logic [CW-1:0] err_cnt;
    logic          seen;
  } det_state_t;

  det_state_t    st_r;
  det_state_t    st_nxt;
  logic          bit_err;
  logic          win_end;
  logic [CW-1:0] err_total;

  ////////////////////////////////////////////////////////////////////////////////
  // Two equal bits in a row break the alternation; a few are tolerated per window
  // so a line error rate near one in a thousand still holds the flag.
  always_comb begin
    st_nxt    = st_r;
    bit_err   = (bit_i == st_r.prev_bit);
    win_end   = bit_valid_i && (st_r.bit_cnt == e1_rx_status_pkg::AUX_LAST_BIT);
    err_total = st_r.err_cnt + CW'(bit_err);
    if (bit_valid_i) begin
      st_nxt.prev_bit = bit_i;
      if (win_end) begin
        st_nxt.bit_cnt = '0;
        st_nxt.err_cnt = '0;
        st_nxt.seen    = (err_total <= e1_rx_status_pkg::AUX_ERR_LIMIT); // RL4
      end else begin
        st_nxt.bit_cnt = st_r.bit_cnt + CW'(1);
        st_nxt.err_cnt = err_total;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign seen_o = st_r.seen;

  ////////////////////////////////////////////////////////////////////////////////
  aux_window_edge_a : assert property ( // RL4
    @(posedge core_clk_i) disable iff (rst_i)
    !$stable(st_r.seen) |-> $past(win_end && ce_i))
    else $error("pattern flag moved inside a window");

  aux_error_drop_a : assert property ( // RL4
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && win_end && (err_total > e1_rx_status_pkg::AUX_ERR_LIMIT)) |=> !st_r.seen)
    else $error("pattern flag kept despite errors");
endmodule
`default_nettype wire

/* logic/e1_rx_status_regs.sv */
// Receive status register bank: slips, buffer phase, alignment capture, loss, dejitter
// Notes on behaviour
// RL1: Each controlled frame slip inverts the slip event toggle bit.
// RL2: Slip direction is one for a repeated frame, zero for a lost frame.
// RL3: Bit 5 shows one when buffer delay exceeds one frame.
// RL4: Alternating pattern flag after 512 alternating bits, tolerant of sparse errors.
// RL5: Frame offset toggle flips when timeslot count MSB falls.
// RL6: Three sub-bit depth bits weight one, half and eighth clock.
// RL7: Five-bit timeslot offset count, refreshed every 250 us.
// RL8: Three-bit bit offset count, refreshed with the timeslot count.
// RL9: First alignment signal bit captured into bit 7.
// RL10: Alignment signal bits two to eight captured into bits 6 to 0.
// RL11: Loss flag after signal below threshold for 1 ms; clears otherwise.
// RL12: Slow flag while dejittered clock is stretched.
// RL13: Fast flag while dejittered clock is shortened.
// RL14: Empty flag when the dejitter FIFO holds nothing.
// RL15: Flag when at least four dejitter FIFO locations are used.
// RL16: Flag when the dejitter FIFO is at least half full.
// RL17: Flag when at most four dejitter FIFO locations are free.
// RL18: Full flag when every dejitter FIFO location is used.
// RL19: All words read-only; writes ignored; unused bits read zero.
// RL20: Phase fields are sampled together in one coherent update.
`timescale 1ns/1ps
`default_nettype none
module e1_rx_status_regs #(
  parameter int unsigned PHASE_REFRESH_CYCLES = e1_rx_status_pkg::PHASE_REFRESH_CYCLES,
  parameter int unsigned LOS_MIN_CYCLES       = e1_rx_status_pkg::LOS_MIN_CYCLES
) (
  input  wire logic                                      core_clk_i,
  input  wire logic                                      rst_i,
  input  wire logic                                      ce_i,
  input  wire logic                                      cs_i,
  input  wire logic                                      rd_i,
  input  wire logic                                      wr_i,
  input  wire logic [e1_rx_status_pkg::ADDR_W-1:0]       addr_i,
  output logic      [e1_rx_status_pkg::DATA_W-1:0]       rdata_o,
  output logic                                           ack_o,
  input  wire logic                                      slip_i,
  input  wire logic                                      slip_repeat_i,
  input  wire logic                                      buf_over_frame_i,
  input  wire logic [e1_rx_status_pkg::TS_W-1:0]         buf_ts_i,
  input  wire logic [e1_rx_status_pkg::BC_W-1:0]         buf_bc_i,
  input  wire logic [e1_rx_status_pkg::SBD_W-1:0]        buf_sbd_i,
  input  wire logic                                      rx_bit_i,
  input  wire logic                                      rx_bit_valid_i,
  input  wire logic [e1_rx_status_pkg::DATA_W-1:0]       fas_byte_i,
  input  wire logic                                      fas_strobe_i,
  input  wire logic                                      below_threshold_i,
  input  wire logic                                      ja_clk_slow_i,
  input  wire logic                                      ja_clk_fast_i,
  input  wire logic [e1_rx_status_pkg::JA_FILL_W-1:0]    ja_fill_i
);
  localparam int CW = e1_rx_status_pkg::CNT_W;
  localparam int DW = e1_rx_status_pkg::DATA_W;

  typedef struct packed {
    logic                          slip_toggle;
    logic                          slip_dir;
    logic                          frame_toggle;
    logic                          prev_ts_msb;
    logic [DW-1:0]                 fas_byte;
    e1_rx_status_pkg::los_state_t  los_state;
    logic [CW-1:0]                 los_cnt;
    logic                          ja_slow;
    logic                          ja_fast;
    logic                          ja_empty;
    logic                          ja_four_used;
    logic                          ja_half;
    logic                          ja_four_free;
    logic                          ja_full;
    logic [DW-1:0]                 rdata;
    logic                          ack;
  } regs_t;

  localparam regs_t REGS_RESET = '{los_state: e1_rx_status_pkg::LOS_CLEAR, default: '0};

  regs_t                         st_r;
  regs_t                         st_nxt;
  logic [DW-1:0]                 read_byte;
  logic                          aux_seen;
  e1_rx_status_pkg::phase_word_t live_word;

  phase_snap_if snap_if ();

  ////////////////////////////////////////////////////////////////////////////////
  assign live_word = '{over: buf_over_frame_i, ts: buf_ts_i, bc: buf_bc_i, sbd: buf_sbd_i};

  phase_snapshot #(
    .REFRESH_CYCLES (PHASE_REFRESH_CYCLES)
  ) u_phase_snapshot (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .live_word_i (live_word),
    .snap        (snap_if.producer)
  );

  alt_pattern_detect u_alt_pattern_detect (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .bit_i       (rx_bit_i),
    .bit_valid_i (rx_bit_valid_i),
    .seen_o      (aux_seen)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt    = st_r;
    read_byte = '0;

    // Slip reporting
    if (slip_i) begin
      st_nxt.slip_toggle = !st_r.slip_toggle; // RL1
      st_nxt.slip_dir    = slip_repeat_i; // RL2
    end

    // Frame toggle follows the sampled count, so it moves only at refreshes
    if (snap_if.update) begin
      st_nxt.prev_ts_msb = snap_if.word.ts[e1_rx_status_pkg::TS_MSB];
      if (st_r.prev_ts_msb && !snap_if.word.ts[e1_rx_status_pkg::TS_MSB]) begin
        st_nxt.frame_toggle = !st_r.frame_toggle; // RL5
      end
    end

    // Alignment signal capture, first received bit in the top position
    if (fas_strobe_i) begin
      st_nxt.fas_byte = fas_byte_i; // RL9 RL10
    end

    // Loss of signal qualification
    case (st_r.los_state)
      e1_rx_status_pkg::LOS_CLEAR: begin
        if (below_threshold_i) begin
          st_nxt.los_state = e1_rx_status_pkg::LOS_TIMING;
          st_nxt.los_cnt   = CW'(1);
        end
      end
      e1_rx_status_pkg::LOS_TIMING: begin
        if (!below_threshold_i) begin
          st_nxt.los_state = e1_rx_status_pkg::LOS_CLEAR;
          st_nxt.los_cnt   = '0;
        end else if (st_r.los_cnt == CW'(LOS_MIN_CYCLES - 1)) begin
          st_nxt.los_state = e1_rx_status_pkg::LOS_LOST; // RL11
        end else begin
          st_nxt.los_cnt = st_r.los_cnt + CW'(1);
        end
      end
      e1_rx_status_pkg::LOS_LOST: begin
        if (!below_threshold_i) begin
          st_nxt.los_state = e1_rx_status_pkg::LOS_CLEAR; // RL11
          st_nxt.los_cnt   = '0;
        end
      end
      default: begin
        st_nxt.los_state = e1_rx_status_pkg::LOS_CLEAR;
        st_nxt.los_cnt   = '0;
      end
    endcase

    // Dejitter FIFO flags, one cycle behind the fill level
    st_nxt.ja_slow      = ja_clk_slow_i; // RL12
    st_nxt.ja_fast      = ja_clk_fast_i; // RL13
    st_nxt.ja_empty     = (ja_fill_i == e1_rx_status_pkg::JA_EMPTY_FILL); // RL14
    st_nxt.ja_four_used = (ja_fill_i >= e1_rx_status_pkg::JA_MARGIN); // RL15
    st_nxt.ja_half      = (ja_fill_i >= e1_rx_status_pkg::JA_HALF_FILL); // RL16
    st_nxt.ja_four_free = (ja_fill_i >= e1_rx_status_pkg::JA_NEAR_FULL_FILL); // RL17
    st_nxt.ja_full      = (ja_fill_i >= e1_rx_status_pkg::JA_DEPTH_FILL); // RL18

    // Read decode; unused positions and unmapped addresses stay zero
    case (addr_i)
      e1_rx_status_pkg::ADDR_SLIP_PATTERN: begin
        read_byte[e1_rx_status_pkg::SLIP_TOGGLE_BIT]  = st_r.slip_toggle;
        read_byte[e1_rx_status_pkg::SLIP_DIR_BIT]     = st_r.slip_dir;
        read_byte[e1_rx_status_pkg::OVER_FRAME_BIT]   = snap_if.word.over; // RL3
        read_byte[e1_rx_status_pkg::AUX_BIT]          = aux_seen;
        read_byte[e1_rx_status_pkg::FRAME_TOGGLE_BIT] = st_r.frame_toggle;
        read_byte[e1_rx_status_pkg::SBD_LSB +: e1_rx_status_pkg::SBD_W] =
          snap_if.word.sbd; // RL6
      end
      e1_rx_status_pkg::ADDR_BUF_PHASE: begin
        read_byte[e1_rx_status_pkg::TS_LSB +: e1_rx_status_pkg::TS_W] = snap_if.word.ts; // RL7
        read_byte[e1_rx_status_pkg::BC_LSB +: e1_rx_status_pkg::BC_W] = snap_if.word.bc; // RL8
      end
      e1_rx_status_pkg::ADDR_FAS: begin
        read_byte = st_r.fas_byte;
      end
      e1_rx_status_pkg::ADDR_LINE: begin
        read_byte[e1_rx_status_pkg::LOS_BIT] =
          (st_r.los_state == e1_rx_status_pkg::LOS_LOST);
      end
      e1_rx_status_pkg::ADDR_DEJITTER: begin
        read_byte[e1_rx_status_pkg::JA_SLOW_BIT]      = st_r.ja_slow;
        read_byte[e1_rx_status_pkg::JA_FAST_BIT]      = st_r.ja_fast;
        read_byte[e1_rx_status_pkg::JA_EMPTY_BIT]     = st_r.ja_empty;
        read_byte[e1_rx_status_pkg::JA_FOUR_USED_BIT] = st_r.ja_four_used;
        read_byte[e1_rx_status_pkg::JA_HALF_BIT]      = st_r.ja_half;
        read_byte[e1_rx_status_pkg::JA_FOUR_FREE_BIT] = st_r.ja_four_free;
        read_byte[e1_rx_status_pkg::JA_FULL_BIT]      = st_r.ja_full;
      end
      default: begin
        read_byte = '0;
      end
    endcase

    // Writes are acknowledged but change nothing
    st_nxt.ack = cs_i && (rd_i || wr_i); // RL19
    if (cs_i && rd_i) begin
      st_nxt.rdata = read_byte;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_r <= REGS_RESET;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o = st_r.rdata;
  assign ack_o   = st_r.ack;

  ////////////////////////////////////////////////////////////////////////////////
  sequence host_read(logic [7:0] a);
    ce_i && cs_i && rd_i && (addr_i == a);
  endsequence

  sequence host_write_only;
    ce_i && cs_i && wr_i && !rd_i;
  endsequence

  slip_toggle_a : assert property ( // RL1
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && slip_i) |=> (st_r.slip_toggle != $past(st_r.slip_toggle)))
    else $error("slip toggle did not invert");

  slip_dir_a : assert property ( // RL2
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && slip_i) |=> (st_r.slip_dir == $past(slip_repeat_i)))
    else $error("slip direction not recorded");

  over_frame_read_a : assert property ( // RL3
    @(posedge core_clk_i) disable iff (rst_i)
    host_read(e1_rx_status_pkg::ADDR_SLIP_PATTERN) |=>
      ack_o && rdata_o[e1_rx_status_pkg::OVER_FRAME_BIT] == $past(snap_if.word.over))
    else $error("frame delay bit misreported");

  frame_toggle_a : assert property ( // RL5
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && snap_if.update && st_r.prev_ts_msb &&
     !snap_if.word.ts[e1_rx_status_pkg::TS_MSB]) |=>
      (st_r.frame_toggle != $past(st_r.frame_toggle)))
    else $error("frame toggle missed falling count MSB");

  phase_read_a : assert property ( // RL7 RL8
    @(posedge core_clk_i) disable iff (rst_i)
    host_read(e1_rx_status_pkg::ADDR_BUF_PHASE) |=>
      rdata_o == {$past(snap_if.word.ts), $past(snap_if.word.bc)})
    else $error("phase word read mismatch");

  fas_capture_a : assert property ( // RL9 RL10
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && fas_strobe_i) ##1 (ce_i && !fas_strobe_i) ##1
      (ce_i && cs_i && rd_i && !fas_strobe_i && (addr_i == e1_rx_status_pkg::ADDR_FAS)) |=>
      rdata_o == $past(fas_byte_i, 3))
    else $error("alignment byte not captured");

  los_set_a : assert property ( // RL11
    @(posedge core_clk_i) disable iff (rst_i)
    $rose(st_r.los_state == e1_rx_status_pkg::LOS_LOST) |->
      $past(st_r.los_cnt) == CW'(LOS_MIN_CYCLES - 1))
    else $error("loss flag set before minimum time");

  los_clear_a : assert property ( // RL11
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && !below_threshold_i) |=> st_r.los_state != e1_rx_status_pkg::LOS_LOST)
    else $error("loss flag held with signal present");

  ja_flags_a : assert property ( // RL14 RL15 RL16 RL17 RL18
    @(posedge core_clk_i) disable iff (rst_i)
    ce_i |=> (st_r.ja_full == ($past(ja_fill_i) >= e1_rx_status_pkg::JA_DEPTH_FILL)) &&
      (st_r.ja_empty == ($past(ja_fill_i) == e1_rx_status_pkg::JA_EMPTY_FILL)) &&
      (st_r.ja_four_free == ($past(ja_fill_i) >= e1_rx_status_pkg::JA_NEAR_FULL_FILL)) &&
      (st_r.ja_half == ($past(ja_fill_i) >= e1_rx_status_pkg::JA_HALF_FILL)) &&
      (st_r.ja_four_used == ($past(ja_fill_i) >= e1_rx_status_pkg::JA_MARGIN)))
    else $error("dejitter fill flag wrong");

  ja_clock_a : assert property ( // RL12 RL13
    @(posedge core_clk_i) disable iff (rst_i)
    ce_i |=> st_r.ja_slow == $past(ja_clk_slow_i) && st_r.ja_fast == $past(ja_clk_fast_i))
    else $error("dejitter clock flag wrong");

  unused_zero_a : assert property ( // RL19
    @(posedge core_clk_i) disable iff (rst_i)
    host_read(e1_rx_status_pkg::ADDR_LINE) |=> rdata_o[e1_rx_status_pkg::LOS_BIT-1:0] == '0)
    else $error("unused line status bits not zero");

  write_ignored_a : assert property ( // RL19
    @(posedge core_clk_i) disable iff (rst_i)
    host_write_only |=> ack_o && $stable(rdata_o))
    else $error("write disturbed read data");
endmodule
`default_nettype wire

/* test/line_bit_source.sv */
// Received line bit stream model for the status bank
`timescale 1ns/1ps
`default_nettype none
module line_bit_source (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pattern_on_i,
  output logic      bit_o,
  output logic      valid_o
);
  // One bit every other clock; line rate stays well below the core rate
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bit_o   <= 1'b0;
      valid_o <= 1'b0;
    end else begin
      valid_o <= ~valid_o;
      // Steady ones when off, so no pattern is ever seen by accident
      if (valid_o) begin
        bit_o <= pattern_on_i ? ~bit_o : 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* test/e1_rx_status_regs_tb_top.sv */
// Register level test of the receive status bank
`timescale 1ns/1ps
`default_nettype none
module e1_rx_status_regs_tb_top;
  logic       core_clk_i;
  logic       rst_i = 1'b1;
  logic       ce_i = 1'b1;
  logic       cs_i = 1'b0;
  logic       rd_i = 1'b0;
  logic       wr_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] rdata_o;
  logic       ack_o;
  logic       slip_i = 1'b0;
  logic       rep_i = 1'b0;
  logic       over_i = 1'b0;
  logic [4:0] ts_i = 5'h00;
  logic [2:0] bc_i = 3'h0;
  logic [2:0] sbd_i = 3'h0;
  logic       bit_w;
  logic       bitv_w;
  logic       pat_i = 1'b0;
  logic [7:0] fas_i = 8'h00;
  logic       fstb_i = 1'b0;
  logic       below_i = 1'b0;
  logic       slow_i = 1'b0;
  logic       fast_i = 1'b0;
  logic [5:0] fill_i = 6'h00;
  int         n_mismatch = 0;
  int         samples_checked = 0;
  int         fills [8] = '{0, 3, 4, 15, 16, 27, 28, 32};
  logic [7:0] fas_tbl [2] = '{8'h9B, 8'h1B};
  ////////////////////////////////////////////////////////////////////////////
  e1_rx_status_regs #(.PHASE_REFRESH_CYCLES(20), .LOS_MIN_CYCLES(8)) DUT (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .cs_i(cs_i), .rd_i(rd_i),
    .wr_i(wr_i), .addr_i(addr_i), .rdata_o(rdata_o), .ack_o(ack_o), .slip_i(slip_i),
    .slip_repeat_i(rep_i), .buf_over_frame_i(over_i), .buf_ts_i(ts_i), .buf_bc_i(bc_i),
    .buf_sbd_i(sbd_i), .rx_bit_i(bit_w), .rx_bit_valid_i(bitv_w), .fas_byte_i(fas_i),
    .fas_strobe_i(fstb_i), .below_threshold_i(below_i), .ja_clk_slow_i(slow_i),
    .ja_clk_fast_i(fast_i), .ja_fill_i(fill_i));
  line_bit_source line (.clk_i(core_clk_i), .rst_i(rst_i), .pattern_on_i(pat_i),
    .bit_o(bit_w), .valid_o(bitv_w));
  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One-cycle strobe; answer is fixed one cycle later, so no wait loop.
  // Returns on a rising edge so that callers drive their inputs there.
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    cs_i <= 1'b1;
    rd_i <= ~w;
    wr_i <= w;
    addr_i <= a;
    @(posedge core_clk_i);
    cs_i <= 1'b0;
    rd_i <= 1'b0;
    wr_i <= 1'b0;
    #1;
    chk({7'h00, ack_o}, 8'h01);
    chk(rdata_o, exp);
    @(posedge core_clk_i);
  endtask
  task automatic print_verdict;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  initial begin
    #200000;
    n_mismatch++;
    print_verdict;
  end
  initial begin
    cyc(4);
    rst_i <= 1'b0;
    acc(1'b0, 8'h13, 8'h00);
    acc(1'b0, 8'h17, 8'h20);
    acc(1'b0, 8'h20, 8'h00);
    slip_i <= 1'b1;
    rep_i <= 1'b1;
    cyc(1);
    slip_i <= 1'b0;
    acc(1'b0, 8'h13, 8'hC0);
    slip_i <= 1'b1;
    rep_i <= 1'b0;
    cyc(1);
    slip_i <= 1'b0;
    acc(1'b0, 8'h13, 8'h00);
    over_i <= 1'b1;
    ts_i <= 5'h1F;
    bc_i <= 3'h3;
    sbd_i <= 3'h5;
    cyc(25);
    acc(1'b0, 8'h14, 8'hFB);
    acc(1'b0, 8'h13, 8'h25);
    ts_i <= 5'h00;
    cyc(25);
    acc(1'b0, 8'h13, 8'h2D);
    acc(1'b0, 8'h14, 8'h03);
    for (int i = 0; i < 2; i++) begin
      fas_i <= fas_tbl[i];
      fstb_i <= 1'b1;
      cyc(1);
      fstb_i <= 1'b0;
      acc(1'b0, 8'h15, fas_tbl[i]);
    end
    // Write must ack yet leave both read data and the word untouched
    acc(1'b1, 8'h15, 8'h1B);
    acc(1'b0, 8'h15, 8'h1B);
    below_i <= 1'b1;
    cyc(3);
    acc(1'b0, 8'h16, 8'h00);
    cyc(10);
    acc(1'b0, 8'h16, 8'h80);
    below_i <= 1'b0;
    cyc(2);
    acc(1'b0, 8'h16, 8'h00);
    for (int i = 0; i < 8; i++) begin
      fill_i <= 6'(fills[i]);
      slow_i <= i[0];
      fast_i <= i[1];
      cyc(2);
      acc(1'b0, 8'h17, {i[0], i[1], fills[i] == 0, fills[i] >= 4, fills[i] >= 16,
        fills[i] >= 28, fills[i] >= 32, 1'b0});
    end
    // Flag moves only at window ends, hence two full windows of wait
    pat_i <= 1'b1;
    cyc(2200);
    acc(1'b0, 8'h13, 8'h3D);
    pat_i <= 1'b0;
    cyc(2200);
    acc(1'b0, 8'h13, 8'h2D);
    // Slips offered while the enable is low must not move the toggle
    ce_i <= 1'b0;
    slip_i <= 1'b1;
    cyc(3);
    ce_i <= 1'b1;
    slip_i <= 1'b0;
    acc(1'b0, 8'h13, 8'h2D);
    print_verdict;
  end
endmodule
`default_nettype wire
